/* src/srp_top.v */
/*
  Spectral result FIFO with persistence filter, reached over an I2C
  target port sampled on core_clk.
  Assumes scl and sda come from pins; measurement inputs are on core_clk.
*/
// Operation
// [R1] Interrupt after configured run outside window
// [R2] Setting zero: every sample interrupts
// [R3] Codes 1-3 direct, 4 gives 5, then 5x(code-3)
// [R4] In-window sample clears the run counter
// [R5] Compare only the selected threshold channel
// [R6] FIFO is 128 entries of two bytes
// [R7] Entry into full FIFO: overflow, data dropped
// [R8] Data at FE/FF, pointer wraps FF to FE
// [R9] Reads of any length accepted
// [R10] Reading FF advances pointer, lowers fill
// [R11] Block reads update once per entry
// [R12] Empty FIFO reads return zero
// [R13] Data indication while unread data held
// [R14] Fill count reports unread entries 0..128
// [R15] Source bits 1-6 store channels 0-5
// [R16] Source bit 0 stores the status byte
// [R17] Host enables status source with auto gain
// [R18] Reading count or source keeps FIFO intact
`include "srp_defines.vh"
`default_nettype none

module srp_top (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Serial link
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  // Measurement results
  input wire sample_valid,
  input wire [7:0] measurement_status_byte,
  input wire [95:0] channel_data,
  // Threshold settings
  input wire [15:0] spectral_low_threshold,
  input wire [15:0] spectral_high_threshold,
  input wire [2:0] threshold_channel_select,
  // Indications
  output wire spectral_irq,
  output reg fifo_data_irq,
  output reg fifo_overflow
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_ADDR_ACK = 4'h2;
  localparam [3:0] ST_REG = 4'h3;
  localparam [3:0] ST_REG_ACK = 4'h4;
  localparam [3:0] ST_WDATA = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RDATA = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;

  // Link synchronisers
  reg scl_s1, scl_s2, scl_d;
  reg sda_s1, sda_s2, sda_d;
  wire scl_rise, scl_fall, bus_start, bus_stop;

  // Serial engine
  reg [3:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] tx;
  reg [7:0] reg_ptr;
  reg rw;
  reg acked;
  reg pop_req;
  reg src_wr;
  reg [3:0] persistence_count_code;
  reg [`SRP_SRC_W-1:0] fifo_source_select;

  // FIFO control
  reg [7:0] fifo_fill_count;
  reg [`SRP_FIFO_AW-1:0] wr_ptr;
  reg [`SRP_FIFO_AW-1:0] rd_ptr;
  reg [`SRP_SRC_W-1:0] wr_pending;
  reg [7:0] snap_status;
  reg [95:0] snap_ch;
  wire [`SRP_FIFO_DW-1:0] head;
  wire [`SRP_SRC_W-1:0] wr_pick;
  wire [`SRP_FIFO_DW-1:0] wr_entry;
  wire push, fifo_full, wr_ok;
  reg [7:0] next_fill;

  // Read decode
  wire [7:0] rd_byte;
  wire rd_pop;
  wire [7:0] ptr_next;
  wire [15:0] sel_sample;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [`SRP_SRC_W-1:0] lowest_bit;
    input [`SRP_SRC_W-1:0] v;
    begin
      lowest_bit = v & (~v + 7'h01);
    end
  endfunction

  function [15:0] chan_of;
    input [2:0] idx;
    input [95:0] bus;
    begin
      case (idx)
        3'h1: chan_of = bus[31:16];
        3'h2: chan_of = bus[47:32];
        3'h3: chan_of = bus[63:48];
        3'h4: chan_of = bus[79:64];
        3'h5: chan_of = bus[95:80];
        default: chan_of = bus[15:0];
      endcase
    end
  endfunction

  function [7:0] reg_read;
    input [7:0] addr;
    input [3:0] spectral_irq_persistence;
    input [`SRP_SRC_W-1:0] src;
    input [7:0] fill;
    input [15:0] word;
    begin
      case (addr)
        `SRP_ADDR_PERSIST: reg_read = {4'h0, spectral_irq_persistence};
        `SRP_ADDR_SRC_SEL: reg_read = {1'b0, src}; // [R18]
        `SRP_ADDR_FILL: reg_read = fill; // [R14] [R18]
        `SRP_ADDR_PORT_LO: reg_read = (fill != 8'h00) ? word[7:0] : 8'h00; // [R12]
        `SRP_ADDR_PORT_HI: reg_read = (fill != 8'h00) ? word[15:8] : 8'h00; // [R12]
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  assign rd_byte = reg_read(reg_ptr, persistence_count_code, fifo_source_select,
                            fifo_fill_count, head);
  assign rd_pop = (reg_ptr == `SRP_ADDR_PORT_HI) && (fifo_fill_count != 8'h00); // [R10] [R11]
  assign ptr_next = (reg_ptr == `SRP_ADDR_PORT_HI) ? `SRP_ADDR_PORT_LO :
                    reg_ptr + 8'h01; // [R8]

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      reg_ptr <= 8'h00;
      rw <= 1'b0;
      acked <= 1'b0;
      pop_req <= 1'b0;
      src_wr <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      persistence_count_code <= `SRP_PERSIST_RST;
      fifo_source_select <= `SRP_SRC_SEL_RST;
    end else begin
      pop_req <= 1'b0;
      src_wr <= 1'b0;
      sda_out <= 1'b0;
      if (bus_start) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        if (state == ST_ADDR || state == ST_REG || state == ST_WDATA) begin
          shreg <= {shreg[6:0], sda_s2};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (state == ST_RACK) begin
          acked <= ~sda_s2;
        end
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bit_cnt == 4'h8) begin
              if (shreg[7:1] == `SRP_I2C_ADDR) begin
                sda_oe <= 1'b1;
                rw <= shreg[0];
                state <= ST_ADDR_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (rw) begin
              tx <= {rd_byte[6:0], 1'b0};
              sda_oe <= ~rd_byte[7];
              pop_req <= rd_pop; // [R10]
              reg_ptr <= ptr_next; // [R8]
              bit_cnt <= 4'h1;
              state <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              bit_cnt <= 4'h0;
              state <= ST_REG;
            end
          end
          ST_REG: begin
            if (bit_cnt == 4'h8) begin
              reg_ptr <= shreg;
              sda_oe <= 1'b1;
              state <= ST_REG_ACK;
            end
          end
          ST_REG_ACK, ST_WACK: begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            state <= ST_WDATA;
          end
          ST_WDATA: begin
            if (bit_cnt == 4'h8) begin
              if (reg_ptr == `SRP_ADDR_PERSIST) begin
                persistence_count_code <= shreg[3:0];
              end
              if (reg_ptr == `SRP_ADDR_SRC_SEL) begin
                fifo_source_select <= shreg[`SRP_SRC_W-1:0];
                src_wr <= 1'b1;
              end
              reg_ptr <= ptr_next;
              sda_oe <= 1'b1;
              state <= ST_WACK;
            end
          end
          ST_RDATA: begin
            if (bit_cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state <= ST_RACK;
            end else begin
              sda_oe <= ~tx[7];
              tx <= {tx[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_RACK: begin
            if (acked) begin
              // Unlimited block length: keep serving while acknowledged
              tx <= {rd_byte[6:0], 1'b0}; // [R9]
              sda_oe <= ~rd_byte[7];
              pop_req <= rd_pop; // [R11]
              reg_ptr <= ptr_next; // [R8]
              bit_cnt <= 4'h1;
              state <= ST_RDATA;
            end else begin
              state <= ST_IDLE;
            end
          end
          default: begin
            sda_oe <= 1'b0;
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO writer
  // ----------------------------------------------------------------
  assign wr_pick = lowest_bit(wr_pending);
  assign wr_entry = wr_pick[`SRP_SRC_STATUS_BIT] ? {8'h00, snap_status} : // [R16]
                    wr_pick[2] ? snap_ch[31:16] :
                    wr_pick[3] ? snap_ch[47:32] :
                    wr_pick[4] ? snap_ch[63:48] :
                    wr_pick[5] ? snap_ch[79:64] :
                    wr_pick[6] ? snap_ch[95:80] :
                    snap_ch[15:0]; // [R15]
  assign push = (wr_pending != 7'h00);
  assign fifo_full = (fifo_fill_count == `SRP_FIFO_DEPTH);
  assign wr_ok = push & ~fifo_full; // [R7]

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_pending <= 7'h00;
      snap_status <= 8'h00;
      snap_ch <= 96'h0;
    end else begin
      if (!push) begin
        if (sample_valid) begin
          wr_pending <= fifo_source_select; // [R15] [R16]
          snap_status <= measurement_status_byte;
          snap_ch <= channel_data;
        end
      end else begin
        wr_pending <= wr_pending & ~wr_pick;
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO pointers and level
  // ----------------------------------------------------------------
  always @* begin
    next_fill = fifo_fill_count;
    if (wr_ok && !pop_req) begin
      next_fill = fifo_fill_count + 8'h01;
    end else if (!wr_ok && pop_req) begin
      next_fill = fifo_fill_count - 8'h01; // [R10] [R11]
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fifo_fill_count <= 8'h00;
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      fifo_data_irq <= 1'b0;
      fifo_overflow <= 1'b0;
    end else begin
      fifo_fill_count <= next_fill; // [R14]
      fifo_data_irq <= (next_fill != 8'h00); // [R13]
      if (wr_ok) begin
        wr_ptr <= wr_ptr + 7'h01;
      end
      if (pop_req) begin
        rd_ptr <= rd_ptr + 7'h01; // [R10] [R11]
      end
      if (push && fifo_full) begin
        fifo_overflow <= 1'b1; // [R7]
      end else if (src_wr) begin
        fifo_overflow <= 1'b0;
      end
    end
  end

  srp_fifo_mem u_mem (
    .core_clk(core_clk),
    .wr_en(wr_ok),
    .wr_addr(wr_ptr),
    .wr_data(wr_entry),
    .rd_addr(rd_ptr),
    .rd_data(head)
  );

  // ----------------------------------------------------------------
  // Persistence filter
  // ----------------------------------------------------------------
  assign sel_sample = chan_of(threshold_channel_select, channel_data); // [R5]

  srp_persist u_persist (
    .core_clk(core_clk),
    .rst(rst),
    .sample_valid(sample_valid),
    .sample(sel_sample),
    .spectral_low_threshold(spectral_low_threshold),
    .spectral_high_threshold(spectral_high_threshold),
    .persistence_count_code(persistence_count_code),
    .spectral_irq(spectral_irq)
  );

endmodule
`default_nettype wire

/* src/srp_defines.vh */
/*
  Constants of the spectral result FIFO and persistence filter:
  register addresses, reset values, field positions and sizes.
  Assumes it is included by bare name from the design files.
*/
`ifndef SRP_DEFINES_VH
`define SRP_DEFINES_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define SRP_ADDR_PERSIST 8'hBD
`define SRP_ADDR_SRC_SEL 8'hFC
`define SRP_ADDR_FILL 8'hFD
`define SRP_ADDR_PORT_LO 8'hFE
`define SRP_ADDR_PORT_HI 8'hFF

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define SRP_PERSIST_RST 4'h0
`define SRP_SRC_SEL_RST 7'h00
`define SRP_SRC_STATUS_BIT 0
`define SRP_SRC_CH0_BIT 1
`define SRP_SRC_W 7

// ----------------------------------------------------------------
// FIFO geometry
// ----------------------------------------------------------------
`define SRP_FIFO_AW 7
`define SRP_FIFO_DW 16
`define SRP_FIFO_DEPTH 8'h80

// ----------------------------------------------------------------
// Persistence counts and link
// ----------------------------------------------------------------
`define SRP_SPECTRAL_IRQ_PERSISTENCE_STEP 6'h05
`define SRP_SPECTRAL_IRQ_PERSISTENCE_OFFSET 4'h3
`define SRP_SPECTRAL_IRQ_PERSISTENCE_FOUR 6'h05
`define SRP_CNT_W 6
// Arbitrary bus address, not tied to any product
`define SRP_I2C_ADDR 7'h2A

`endif

/* src/srp_fifo_mem.v */
/*
  Result FIFO storage: 128 words of 16 bits, one write port and one
  read port whose data come out of a register.
  Assumes pointers and full/empty handling are done by the caller.
*/
`include "srp_defines.vh"
`default_nettype none

module srp_fifo_mem (
  // Clock
  input wire core_clk,
  // Write side
  input wire wr_en,
  input wire [`SRP_FIFO_AW-1:0] wr_addr,
  input wire [`SRP_FIFO_DW-1:0] wr_data,
  // Read side
  input wire [`SRP_FIFO_AW-1:0] rd_addr,
  output reg [`SRP_FIFO_DW-1:0] rd_data
);

  reg [`SRP_FIFO_DW-1:0] store [0:(1<<`SRP_FIFO_AW)-1];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data; // [R6]
    end
    rd_data <= store[rd_addr];
  end

endmodule
`default_nettype wire

/* src/srp_persist.v */
/*
  Spectral interrupt persistence filter on one selected channel.
  Assumes samples and thresholds come from logic on core_clk.
*/
`include "srp_defines.vh"
`default_nettype none

module srp_persist (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Sample stream
  input wire sample_valid,
  input wire [15:0] sample,
  // Window and setting
  input wire [15:0] spectral_low_threshold,
  input wire [15:0] spectral_high_threshold,
  input wire [3:0] persistence_count_code,
  // Event
  output reg spectral_irq
);

  reg [`SRP_CNT_W-1:0] run_cnt;
  wire out_of_range;
  wire [`SRP_CNT_W-1:0] need;
  wire [`SRP_CNT_W-1:0] next_cnt;

  // ----------------------------------------------------------------
  // Required run length
  // ----------------------------------------------------------------
  function [`SRP_CNT_W-1:0] need_of;
    input [3:0] code;
    reg [3:0] over;
    begin
      over = code - `SRP_SPECTRAL_IRQ_PERSISTENCE_OFFSET;
      if (code <= `SRP_SPECTRAL_IRQ_PERSISTENCE_OFFSET) begin
        need_of = {2'b00, code}; // [R3]
      end else if (code == 4'h4) begin
        need_of = `SRP_SPECTRAL_IRQ_PERSISTENCE_FOUR; // [R3]
      end else begin
        need_of = `SRP_SPECTRAL_IRQ_PERSISTENCE_STEP * {2'b00, over}; // [R3]
      end
    end
  endfunction

  assign need = need_of(persistence_count_code);
  assign out_of_range = (sample < spectral_low_threshold) ||
                        (sample > spectral_high_threshold); // [R1]
  assign next_cnt = run_cnt + 6'h01;

  // ----------------------------------------------------------------
  // Run counter
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      run_cnt <= 6'h00;
      spectral_irq <= 1'b0;
    end else begin
      spectral_irq <= 1'b0;
      if (sample_valid) begin
        if (persistence_count_code == 4'h0) begin
          spectral_irq <= 1'b1; // [R2]
          run_cnt <= 6'h00;
        end else if (!out_of_range) begin
          run_cnt <= 6'h00; // [R4]
        end else if (next_cnt >= need) begin
          spectral_irq <= 1'b1; // [R1]
          run_cnt <= 6'h00;
        end else begin
          run_cnt <= next_cnt; // [R1]
        end
      end
    end
  end

endmodule
`default_nettype wire

/* tb/srp_top_props.sv */
/*
  Checker of the result FIFO block: ties each indication to its cause.
  Assumes it is bound to srp_top and sees only its ports.
*/
`default_nettype none
module srp_top_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched ports
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic sample_valid,
  input wire logic spectral_irq,
  input wire logic fifo_data_irq,
  input wire logic fifo_overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Cycle counters
  // ----------------------------------------
  logic scl_q;
  logic [5:0] since_sv;
  logic [5:0] since_fall;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      since_sv <= 6'h3F;
      since_fall <= 6'h3F;
    end else begin
      scl_q <= scl;
      since_sv <= sample_valid ? 6'h00 : since_sv + {5'h00, since_sv != 6'h3F};
      since_fall <= (scl_q && !scl) ? 6'h00 : since_fall + {5'h00, since_fall != 6'h3F};
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_irq_cause;
    spectral_irq |-> $past(sample_valid);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without sample");
  property p_ovf_cause;
    $rose(fifo_overflow) |-> since_sv <= 6'h09;
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without sample");
  property p_ovf_full;
    $rose(fifo_overflow) |-> fifo_data_irq;
  endproperty
  a_ovf_full: assert property (p_ovf_full) else $error("overflow while empty");
  property p_ovf_clear;
    $fell(fifo_overflow) |-> since_fall <= 6'h08;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow lost");
  property p_fifo_data_irq_rise;
    $rose(fifo_data_irq) |-> since_sv <= 6'h09;
  endproperty
  a_fifo_data_irq_rise: assert property (p_fifo_data_irq_rise) else $error("data flag without sample");
  property p_fifo_data_irq_fall;
    $fell(fifo_data_irq) |-> since_fall <= 6'h08;
  endproperty
  a_fifo_data_irq_fall: assert property (p_fifo_data_irq_fall) else $error("data flag fell unread");
  property p_oe_edge;
    $changed(sda_oe) |-> since_fall inside {[2:6]};
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data pin moved off low phase");
  property p_oe_idle;
    since_fall == 6'h3F |-> !sda_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data pin held while idle");
  property p_sda_low;
    !sda_out;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
  cover property (spectral_irq);
  cover property ($rose(fifo_overflow));
  cover property ($fell(fifo_data_irq));
endmodule

bind srp_top srp_top_props i_srp_top_props (
  .core_clk(core_clk), .rst(rst), .scl(scl), .sda_oe(sda_oe), .sda_out(sda_out),
  .sample_valid(sample_valid), .spectral_irq(spectral_irq),
  .fifo_data_irq(fifo_data_irq), .fifo_overflow(fifo_overflow)
);
`default_nettype wire

/* tb/srp_host.sv */
/*
  Serial controller model of the host, 160 ns bit period.
  Assumes the bench resolves the data wire with a pull-up.
*/
`default_nettype none
module srp_host (
  // Link pins
  output logic scl,
  output logic sda_low,
  input wire logic sda,
  // Received byte report
  output logic got,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int Q = 40;
  logic ack;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 1'b0;
    got_byte = 8'h00;
  end
  // Data set in the low phase, sampled mid high phase
  task automatic bit_x(input logic d, output logic b);
    sda_low = !d;
    #Q;
    scl = 1'b1;
    #Q;
    b = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask
  task automatic wr(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_x(v[i], ack);
    bit_x(1'b1, ack);
  endtask
  task automatic rd(input logic last);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, got_byte[i]);
    got = 1'b1;
    bit_x(last, ack);
    got = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/srp_top_tb.sv */
/*
  Self-checking bench of the result FIFO and persistence filter.
  Assumes srp_top, srp_host and the bound checker are compiled.
*/
`include "srp_defines.vh"
`default_nettype none
module srp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst;
  logic sample_valid;
  logic [7:0] stat;
  logic [95:0] chan;
  logic [15:0] lo_th;
  logic [15:0] hi_th;
  logic [2:0] sel;
  logic [7:0] exp_q[$];
  logic [15:0] ref_q[$];
  int fail_count = 0;
  int num_checks = 0;
  int irq_seen = 0;
  int irq_exp = 0;
  int run = 0;
  int code = 0;
  int unsigned seed;
  wire scl, sda_low, sda_oe, got, sirq, firq, ovf;
  wire [7:0] got_byte;
  wire sda = !(sda_low || sda_oe);
  // ----------------------------------------
  // Design, host and monitors
  // ----------------------------------------
  srp_top i_srp_top (
    .core_clk(core_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .sample_valid(sample_valid), .measurement_status_byte(stat), .channel_data(chan),
    .spectral_low_threshold(lo_th), .spectral_high_threshold(hi_th),
    .threshold_channel_select(sel), .spectral_irq(sirq), .fifo_data_irq(firq),
    .fifo_overflow(ovf)
  );
  srp_host i_srp_host (
    .scl(scl), .sda_low(sda_low), .sda(sda), .got(got), .got_byte(got_byte)
  );
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) if (sirq === 1'b1) irq_seen++;
  always @(posedge got) check({8'h00, got_byte}, {8'h00, exp_q.pop_front()});
  initial begin
    #2ms;
    fail_count++;
    summarize();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  function automatic int need_of(input int c);
    return c <= 3 ? c : (c == 4 ? 5 : 5 * (c - 3));
  endfunction
  task automatic sample(input logic outr, input logic [6:0] src, input int gap);
    logic [15:0] v;
    v = outr ? ($urandom % 2 ? lo_th - 16'h0001 : hi_th + 16'h0001) : ($urandom % 2 ? lo_th : hi_th);
    stat = 8'($urandom);
    chan = {$urandom, $urandom, $urandom};
    chan[sel * 16 +: 16] = v;
    sample_valid = 1'b1;
    tick(1);
    sample_valid = 1'b0;
    for (int c = 0; c < 7; c++) if (src[c] && ref_q.size() < 128) begin
      ref_q.push_back(c == 0 ? {8'h00, stat} : chan[c * 16 - 16 +: 16]);
    end
    if (code == 0) irq_exp++;
    else if (!outr) run = 0;
    else if (++run == need_of(code)) begin
      irq_exp++;
      run = 0;
    end
    tick(gap - 1);
  endtask
  task automatic exp_port(input logic hi_byte);
    logic [15:0] e;
    e = (ref_q.size() != 0) ? ref_q[0] : 16'h0000;
    exp_q.push_back(hi_byte ? e[15:8] : e[7:0]);
    if (hi_byte && ref_q.size() != 0) void'(ref_q.pop_front());
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_srp_host.start();
    i_srp_host.wr({`SRP_I2C_ADDR, 1'b0});
    i_srp_host.wr(a);
    i_srp_host.wr(d);
    i_srp_host.stop();
  endtask
  task automatic rd_reg(input logic [7:0] a, input int n);
    i_srp_host.start();
    i_srp_host.wr({`SRP_I2C_ADDR, 1'b0});
    i_srp_host.wr(a);
    rd_cur(n);
  endtask
  task automatic rd_cur(input int n);
    i_srp_host.start();
    i_srp_host.wr({`SRP_I2C_ADDR, 1'b1});
    for (int i = 0; i < n; i++) i_srp_host.rd(i == n - 1);
    i_srp_host.stop();
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    sample_valid = 1'b0;
    stat = 8'h00;
    chan = '0;
    lo_th = 16'h1000;
    hi_th = 16'h2000;
    sel = 3'h0;
    seed = $urandom(32'hD2D4);
    tick(10);
    rst = 1'b0;
    tick(3);
    wr_reg(`SRP_ADDR_FILL, 8'h55);
    repeat (4) exp_q.push_back(8'h00);
    rd_reg(`SRP_ADDR_PERSIST, 1);
    rd_reg(`SRP_ADDR_SRC_SEL, 2);
    rd_reg(8'h10, 1);
    wr_reg(`SRP_ADDR_PERSIST, 8'hF7);
    wr_reg(`SRP_ADDR_SRC_SEL, 8'hFF);
    exp_q.push_back(8'h07);
    exp_q.push_back(8'h7F);
    rd_reg(`SRP_ADDR_PERSIST, 1);
    rd_reg(`SRP_ADDR_SRC_SEL, 1);
    wr_reg(`SRP_ADDR_SRC_SEL, 8'h00);
    for (int k = 0; k < 16; k++) begin
      code = k;
      sel = 3'($urandom % 6);
      lo_th = 16'h0100 + 16'($urandom % 32'h0F00);
      hi_th = lo_th + 16'h0100 + 16'($urandom % 32'h0F00);
      wr_reg(`SRP_ADDR_PERSIST, 8'(k));
      for (int i = 0; i < 2 * (k == 0 ? 2 : need_of(k)); i++) begin
        sample(i != (k == 0 ? 1 : need_of(k) - 1), 7'h00, 2);
      end
      tick(3);
      check(16'(irq_seen), 16'(irq_exp));
    end
    wr_reg(`SRP_ADDR_SRC_SEL, 8'h03);
    repeat (3) sample(1'b0, 7'h03, 10);
    exp_q.push_back(8'h06);
    exp_q.push_back(8'h06);
    rd_reg(`SRP_ADDR_FILL, 1);
    rd_reg(`SRP_ADDR_FILL, 1);
    for (int i = 0; i < 16; i++) exp_port(i[0]);
    exp_q.push_back(8'h00);
    rd_reg(`SRP_ADDR_PORT_LO, 16);
    rd_reg(`SRP_ADDR_FILL, 1);
    for (int b = 0; b < 7; b++) begin
      wr_reg(`SRP_ADDR_SRC_SEL, 8'(1 << b));
      sample(1'b0, 7'(1 << b), 10);
      exp_port(1'b0);
      exp_port(1'b0);
      exp_port(1'b1);
      exp_q.push_back(8'h00);
      rd_reg(`SRP_ADDR_PORT_LO, 1);
      rd_reg(`SRP_ADDR_PORT_LO, 1);
      rd_cur(1);
      rd_reg(`SRP_ADDR_FILL, 1);
    end
    wr_reg(`SRP_ADDR_SRC_SEL, 8'h7F);
    repeat (19) sample(1'b0, 7'h7F, 10);
    check({15'h0000, ovf}, 16'h0001);
    check({15'h0000, firq}, 16'h0001);
    exp_q.push_back(8'h80);
    rd_reg(`SRP_ADDR_FILL, 1);
    for (int i = 0; i < 258; i++) exp_port(i[0]);
    rd_reg(`SRP_ADDR_PORT_LO, 258);
    tick(10);
    check({15'h0000, firq}, 16'h0000);
    check({15'h0000, ovf}, 16'h0001);
    wr_reg(`SRP_ADDR_SRC_SEL, 8'h00);
    tick(10);
    check({15'h0000, ovf}, 16'h0000);
    check(16'(irq_seen), 16'(irq_exp));
    check(16'(exp_q.size()), 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
